//--- verilog/tap_controller.sv
/*
 * Boundary-scan test access port: sixteen-state controller, 3-bit instruction
 * register, bypass, identification and boundary-scan registers.
 * Assumes the test pins arrive asynchronously and the test clock is much
 * slower than clk; edges are found after synchronisation.
 */
// Contract
// - Controller samples mode select at each rising test clock edge.
// - Power-up lands in Test-Logic-Reset with identification instruction, normal function.
// - Run-Test-Idle holds instruction and data registers.
// - Select-DR-Scan goes to Capture-DR on low, Select-IR on high.
// - Capture-DR loads selected register if allowed; then Shift-DR or Exit1-DR.
// - Shift-DR moves selected register one stage toward serial out.
// - Exit1-DR goes Update-DR on high, Pause-DR on low.
// - Pause-DR holds; stays on low, Exit2-DR on high.
// - Exit2-DR goes Update-DR on high, Shift-DR on low.
// - Falling edge in Update-DR copies shift stages to parallel latches.
// - Select-IR goes Capture-IR on low, Test-Logic-Reset on high.
// - Capture-IR loads fixed pattern; then Exit1-IR high, Shift-IR low.
// - Shift-IR shifts instruction toward serial out; leaves to Exit1-IR on high.
// - Exit1-IR goes Pause-IR on low, Update-IR on high.
// - Pause-IR halts shifting; stays on low, Exit2-IR on high.
// - Exit2-IR with high goes to Update-IR.
// - Falling edge in Update-IR latches instruction; then Idle or Select-DR.
// - Instruction register three bits, shift stage plus latched output.
// - Boundary scan for codes 010 and 000; identification for 001.
// - Bypass bit for 111, 011, 100; bypass leaves function undisturbed.
// - Sample captures pins without disturbing function; shift loads new data.
// - Extest drives outputs from boundary latches, captures inputs.
// - Clamp drives outputs from boundary latches, bypass is serial path.
// - Highz floats all digital outputs, bypass is serial path.
// - Identification 32-bit, loads fixed code in Capture-DR, lsb one.
`timescale 1ns/1ps
module tap_controller
(
    // System
    input  wire logic                            clk,
    input  wire logic                            rst,
    // Test pins
    input  wire logic                            test_reset_n,
    input  wire logic                            test_clock,
    input  wire logic                            test_mode_select,
    input  wire logic                            test_serial_in,
    output logic                                 test_serial_out,
    output logic                                 test_serial_out_oe,
    // Functional side of the boundary cells
    input  wire logic [tap_pkg::BSR_WIDTH-1:0]   core_out,
    input  wire logic [tap_pkg::BSR_WIDTH-1:0]   core_oe,
    input  wire logic [tap_pkg::BSR_WIDTH-1:0]   pin_in,
    output logic      [tap_pkg::BSR_WIDTH-1:0]   pin_out,
    output logic      [tap_pkg::BSR_WIDTH-1:0]   pin_oe,
    // Controller status
    output logic                                 in_reset_state
);

    localparam int BW = tap_pkg::BSR_WIDTH;
    localparam logic [31:0] ID_CODE = {tap_pkg::ID_REVISION, tap_pkg::ID_PART, tap_pkg::ID_MAKER, 1'b1};

    typedef struct packed {
        tap_pkg::tap_state_e  tap;
        logic                 tck_prev;
        logic [2:0]           ir_shift;
        logic [2:0]           ir_latch;
        logic                 bypass;
        logic [31:0]          id_shift;
        logic [BW-1:0]        bs_shift;
        logic [BW-1:0]        bs_latch;
        logic [BW-1:0]        bs_oe_latch;
        logic                 tdo;
        logic                 tdo_oe;
        logic [BW-1:0]        pin_out;
        logic [BW-1:0]        pin_oe;
        logic                 in_reset;
    } tap_s;

    tap_s state_reg;
    tap_s state_next;

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_n_s;

    pin_sync u_sync_tck
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (test_clock),
        .level (tck_s)
    );

    pin_sync u_sync_tms
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (test_mode_select),
        .level (tms_s)
    );

    pin_sync u_sync_tdi
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (test_serial_in),
        .level (tdi_s)
    );

    pin_sync u_sync_trst
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (test_reset_n),
        .level (trst_n_s)
    );

    // Standard state graph step on one mode-select sample
    function automatic tap_pkg::tap_state_e next_tap(input tap_pkg::tap_state_e s, input logic m);
        tap_pkg::tap_state_e n;
        n = tap_pkg::ST_RESET;
        case (s)
            tap_pkg::ST_RESET:    n = m ? tap_pkg::ST_RESET   : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE:     n = m ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR:   n = m ? tap_pkg::ST_SEL_IR  : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR:   n = m ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: n = m ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR: n = m ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR: n = m ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: n = m ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR:   n = m ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR:   n = m ? tap_pkg::ST_RESET   : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR:   n = m ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: n = m ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: n = m ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR: n = m ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: n = m ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR:   n = m ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
            default:              n = tap_pkg::ST_RESET;
        endcase
        return n;
    endfunction : next_tap

    function automatic logic sel_boundary(input logic [2:0] ir);
        return (ir == tap_pkg::INSTR_SAMPLE) || (ir == tap_pkg::INSTR_EXTEST);
    endfunction : sel_boundary

    logic rise;
    logic fall;

    assign rise = tck_s && !state_reg.tck_prev;
    assign fall = !tck_s && state_reg.tck_prev;

    always_comb
    begin
        state_next          = state_reg;
        state_next.tck_prev = tck_s;
        if (!trst_n_s)
        begin
            state_next.tap      = tap_pkg::ST_RESET;
            state_next.ir_latch = tap_pkg::INSTR_IDCODE;
            // Release serial out now; the test clock may be stopped
            state_next.tdo_oe   = 1'b0;
            state_next.tdo      = 1'b0;
        end
        else if (rise)
        begin
            // Registers act on the state being left; hold by omission
            case (state_reg.tap)
                tap_pkg::ST_CAP_DR:
                begin
                    if (sel_boundary(state_reg.ir_latch))
                    begin
                        state_next.bs_shift = pin_in;
                    end
                    else if (state_reg.ir_latch == tap_pkg::INSTR_IDCODE)
                    begin
                        state_next.id_shift = ID_CODE;
                    end
                    else
                    begin
                        state_next.bypass = 1'b0;
                    end
                end
                tap_pkg::ST_SHIFT_DR:
                begin
                    if (sel_boundary(state_reg.ir_latch))
                    begin
                        state_next.bs_shift = {tdi_s, state_reg.bs_shift[BW-1:1]};
                    end
                    else if (state_reg.ir_latch == tap_pkg::INSTR_IDCODE)
                    begin
                        state_next.id_shift = {tdi_s, state_reg.id_shift[31:1]};
                    end
                    else
                    begin
                        state_next.bypass = tdi_s;
                    end
                end
                tap_pkg::ST_CAP_IR:
                begin
                    state_next.ir_shift = tap_pkg::IR_CAPTURE;
                end
                tap_pkg::ST_SHIFT_IR:
                begin
                    state_next.ir_shift = {tdi_s, state_reg.ir_shift[2:1]};
                end
                default:
                begin
                    state_next.ir_shift = state_reg.ir_shift;
                end
            endcase
            state_next.tap = next_tap(state_reg.tap, tms_s);
            // Reset entry restores the default instruction with the state
            if (state_next.tap == tap_pkg::ST_RESET)
            begin
                state_next.ir_latch = tap_pkg::INSTR_IDCODE;
            end
        end
        else if (fall)
        begin
            case (state_reg.tap)
                tap_pkg::ST_UPD_DR:
                begin
                    if (sel_boundary(state_reg.ir_latch))
                    begin
                        state_next.bs_latch    = state_reg.bs_shift;
                        state_next.bs_oe_latch = {BW{1'b1}};
                    end
                end
                tap_pkg::ST_UPD_IR:
                begin
                    state_next.ir_latch = state_reg.ir_shift;
                end
                tap_pkg::ST_RESET:
                begin
                    state_next.ir_latch = tap_pkg::INSTR_IDCODE;
                end
                default:
                begin
                    state_next.ir_latch = state_reg.ir_latch;
                end
            endcase
            // Serial out updates on the falling edge
            state_next.tdo_oe = 1'b0;
            state_next.tdo    = 1'b0;
            if (state_reg.tap == tap_pkg::ST_SHIFT_IR)
            begin
                state_next.tdo_oe = 1'b1;
                state_next.tdo    = state_reg.ir_shift[0];
            end
            else if (state_reg.tap == tap_pkg::ST_SHIFT_DR)
            begin
                state_next.tdo_oe = 1'b1;
                if (sel_boundary(state_reg.ir_latch))
                begin
                    state_next.tdo = state_reg.bs_shift[0];
                end
                else if (state_reg.ir_latch == tap_pkg::INSTR_IDCODE)
                begin
                    state_next.tdo = state_reg.id_shift[0];
                end
                else
                begin
                    state_next.tdo = state_reg.bypass;
                end
            end
        end
        // Pin muxing follows the current instruction
        case (state_reg.ir_latch)
            tap_pkg::INSTR_EXTEST, tap_pkg::INSTR_CLAMP:
            begin
                state_next.pin_out = state_reg.bs_latch;
                state_next.pin_oe  = state_reg.bs_oe_latch;
            end
            tap_pkg::INSTR_HIGHZ:
            begin
                state_next.pin_out = '0;
                state_next.pin_oe  = '0;
            end
            default:
            begin
                state_next.pin_out = core_out;
                state_next.pin_oe  = core_oe;
            end
        endcase
        state_next.in_reset = (state_next.tap == tap_pkg::ST_RESET);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg          <= '0;
            state_reg.tap      <= tap_pkg::ST_RESET;
            state_reg.ir_latch <= tap_pkg::INSTR_IDCODE;
            state_reg.in_reset <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign test_serial_out    = state_reg.tdo;
    assign test_serial_out_oe = state_reg.tdo_oe;
    assign pin_out            = state_reg.pin_out;
    assign pin_oe             = state_reg.pin_oe;
    assign in_reset_state     = state_reg.in_reset;

endmodule : tap_controller

//--- verilog/tap_pkg.sv
/*
 * Constants for the boundary-scan test access port: state codes, instruction
 * codes, register widths and sampling figures.
 * Assumes a 50 MHz system clock that oversamples the test clock.
 */
package tap_pkg;

    localparam int IR_WIDTH    = 3;
    localparam int ID_WIDTH    = 32;
    localparam int BSR_WIDTH   = 8;

    localparam logic [2:0] INSTR_EXTEST  = 3'h0;
    localparam logic [2:0] INSTR_IDCODE  = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE  = 3'h2;
    localparam logic [2:0] INSTR_CLAMP   = 3'h3;
    localparam logic [2:0] INSTR_HIGHZ   = 3'h4;
    localparam logic [2:0] INSTR_BYPASS  = 3'h7;

    // Capture-IR pattern, low two bits are binary 01
    localparam logic [2:0] IR_CAPTURE    = 3'h1;

    // Identification: revision, part, maker (values arbitrary), lsb one
    localparam logic [3:0]  ID_REVISION  = 4'h0;
    localparam logic [15:0] ID_PART      = 16'h0a5a;
    localparam logic [10:0] ID_MAKER     = 11'h123;

    localparam int SYNC_STAGES = 3;

    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } tap_state_e;

endpackage : tap_pkg

//--- verilog/pin_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk; output changes when stages two
 * and three agree.
 */
`timescale 1ns/1ps
module pin_sync
(
    // System
    input  wire logic clk,
    input  wire logic rst,
    // Pin and clean level
    input  wire logic pin,
    output logic      level
);

    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    always_comb
    begin
        state_next       = state_reg;
        state_next.stage = {state_reg.stage[1:0], pin};
        if (state_reg.stage[1] == state_reg.stage[2])
        begin
            state_next.level = state_reg.stage[2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;

endmodule : pin_sync

//--- test/tap_chk.sv
/*
 * Checker for tap_controller: reset entry, pin pass-through, serial out timing.
 * Assumes the test pins reach the block unsynchronised, as on the board.
 */
`timescale 1ns/1ps
module tap_chk
(
    // System
    input wire logic                          clk,
    input wire logic                          rst,
    // Test pins
    input wire logic                          test_reset_n,
    input wire logic                          test_clock,
    input wire logic                          test_mode_select,
    input wire logic                          test_serial_in,
    input wire logic                          test_serial_out,
    input wire logic                          test_serial_out_oe,
    // Boundary side
    input wire logic [tap_pkg::BSR_WIDTH-1:0] core_out,
    input wire logic [tap_pkg::BSR_WIDTH-1:0] core_oe,
    input wire logic [tap_pkg::BSR_WIDTH-1:0] pin_in,
    input wire logic [tap_pkg::BSR_WIDTH-1:0] pin_out,
    input wire logic [tap_pkg::BSR_WIDTH-1:0] pin_oe,
    input wire logic                          in_reset_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rst_entry_a: assert property ($fell(rst) |-> in_reset_state)
        else $error("controller not in reset state after rst");
    pin_reset_a: assert property ((!test_reset_n) [*8] |-> in_reset_state)
        else $error("test reset did not force the reset state");
    entry_cause_a: assert property ($rose(in_reset_state) |->
        $past(test_mode_select, 2) || !$past(test_reset_n, 2))
        else $error("reset state entered without cause");
    core_pass_a: assert property (in_reset_state [*2] |=> pin_out == $past(core_out) && pin_oe == $past(core_oe))
        else $error("pins do not follow the core in reset state");
    oe_quiet_a: assert property (in_reset_state [*3] |-> !test_serial_out_oe)
        else $error("serial out driven in reset state");
    oe_shift_a: assert property (test_serial_out_oe && test_reset_n |-> !in_reset_state)
        else $error("serial out enable high in reset state");
    out_edge_a: assert property ($changed(test_serial_out) && test_reset_n |-> !$past(test_clock, 3))
        else $error("serial out changed away from a falling edge");
    oe_edge_a: assert property ($rose(test_serial_out_oe) |-> !$past(test_clock, 3))
        else $error("serial out enable rose away from a falling edge");
endmodule : tap_chk

bind tap_controller tap_chk chk (.clk(clk), .rst(rst), .test_reset_n(test_reset_n), .test_clock(test_clock),
    .test_mode_select(test_mode_select), .test_serial_in(test_serial_in), .test_serial_out(test_serial_out),
    .test_serial_out_oe(test_serial_out_oe), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .in_reset_state(in_reset_state));

//--- test/scan_host.sv
/*
 * Boundary-scan host model: steps the test clock and shifts words LSB first.
 * Assumes clk is the bench clock; the test clock rests low between scans.
 */
`timescale 1ns/1ps
module scan_host
(
    // Bench clock
    input  wire logic        clk,
    // Test pins
    output logic             test_clock,
    output logic             test_mode_select,
    output logic             test_serial_in,
    input  wire logic        serial_line,
    // Shifted word
    output logic [31:0]      result,
    output logic             result_valid
);
    logic tdo_bit;

    initial
    begin
        test_clock       = 1'b0;
        test_mode_select = 1'b1;
        test_serial_in   = 1'b0;
        result           = 32'h0;
        result_valid     = 1'b0;
        tdo_bit          = 1'b0;
    end

    // One 160 ns period; serial out read just before the fall
    task step(input logic tms, input logic tdi);
        @(negedge clk);
        test_mode_select = tms;
        test_serial_in   = tdi;
        repeat (3) @(negedge clk);
        test_clock = 1'b1;
        repeat (4) @(negedge clk);
        tdo_bit    = serial_line;
        test_clock = 1'b0;
    endtask : step

    task scan(input logic ir, input int n, input logic [31:0] din, input logic pause);
        logic [31:0] dout;
        dout = 32'h0;
        step(1'b1, 1'b0);
        if (ir)
            step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1 || (pause && i == n / 2), din[i]);
            dout[i] = tdo_bit;
            if (pause && i == n / 2 && i != n - 1)
            begin
                // Pause twice, then back through the second exit
                step(1'b0, 1'b0);
                step(1'b0, 1'b0);
                step(1'b1, 1'b0);
                step(1'b0, 1'b0);
            end
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        result       = dout;
        result_valid = 1'b1;
        @(negedge clk);
        result_valid   = 1'b0;
        test_serial_in = 1'b1;
    endtask : scan

    task reset5;
        repeat (5) step(1'b1, 1'b0);
    endtask : reset5
endmodule : scan_host

//--- test/tb_top.sv
/*
 * Testbench for tap_controller: instruction and data scans with random pins.
 * Assumes scan_host drives the test pins and tap_chk is bound to the design.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int w = tap_pkg::BSR_WIDTH;
    localparam logic [31:0] id_val = {tap_pkg::ID_REVISION, tap_pkg::ID_PART, tap_pkg::ID_MAKER, 1'b1};
    logic [2:0]   codes [6] = '{tap_pkg::INSTR_SAMPLE, tap_pkg::INSTR_EXTEST, tap_pkg::INSTR_CLAMP,
                                tap_pkg::INSTR_HIGHZ, tap_pkg::INSTR_BYPASS, tap_pkg::INSTR_IDCODE};
    logic         clk, rst, test_reset_n, test_clock, test_mode_select, test_serial_in;
    logic         test_serial_out, test_serial_out_oe, in_reset_state, result_valid, bnd, drive, hz;
    logic [w-1:0] core_out, core_oe, pin_in, pin_out, pin_oe, din, bsr_val, ex, eoe;
    logic [31:0]  result, seed, e;
    logic [31:0]  expq [$];
    int           fails, checks;
    wire          serial_line = test_serial_out_oe ? test_serial_out : 1'bz;

    tap_controller dut (.clk(clk), .rst(rst), .test_reset_n(test_reset_n), .test_clock(test_clock),
        .test_mode_select(test_mode_select), .test_serial_in(test_serial_in), .test_serial_out(test_serial_out),
        .test_serial_out_oe(test_serial_out_oe), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .in_reset_state(in_reset_state));
    scan_host host (.clk(clk), .test_clock(test_clock), .test_mode_select(test_mode_select),
        .test_serial_in(test_serial_in), .serial_line(serial_line), .result(result), .result_valid(result_valid));

    always #10 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task check(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check

    task conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // Oldest note against each shifted word
    always @(posedge clk)
        if (result_valid === 1'b1)
        begin
            e = expq.pop_front();
            check(result, e);
        end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end

    initial
    begin
        {clk, rst, test_reset_n, fails, checks} = {3'b011, 64'h0};
        {seed, core_out, core_oe, pin_in, bsr_val} = {32'hc3879349, 32'h0};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        host.step(1'b0, 1'b0);
        expq.push_back(id_val);
        host.scan(1'b0, 32, 32'h0, 1'b1);
        $display("test default id done");
        foreach (codes[k])
        begin
            seed = xs(seed);
            {din, pin_in, core_oe, core_out} = seed;
            expq.push_back(32'h1);
            host.scan(1'b1, 3, {29'h0, codes[k]}, k[0]);
            bnd = codes[k] == tap_pkg::INSTR_SAMPLE || codes[k] == tap_pkg::INSTR_EXTEST;
            drive = codes[k] == tap_pkg::INSTR_EXTEST || codes[k] == tap_pkg::INSTR_CLAMP;
            hz = codes[k] == tap_pkg::INSTR_HIGHZ;
            ex = codes[k] == tap_pkg::INSTR_IDCODE ? id_val[7:0] : {din[6:0], 1'b0};
            expq.push_back({24'h0, bnd ? pin_in : ex});
            host.scan(1'b0, 8, {24'h0, din}, 1'b0);
            if (bnd)
                bsr_val = din;
            ex = (drive ? bsr_val : core_out) & {w{!hz}};
            eoe = drive ? 8'hff : (hz ? 8'h00 : core_oe);
            check({16'h0, pin_out & {w{!hz}}, pin_oe}, {16'h0, ex, eoe});
            $display("test instruction %h done", codes[k]);
        end
        for (int j = 0; j < 2; j++)
        begin
            expq.push_back(32'h1);
            host.scan(1'b1, 3, {29'h0, tap_pkg::INSTR_BYPASS}, 1'b0);
            if (j == 0)
                host.reset5();
            else
            begin
                test_reset_n = 1'b0;
                repeat (20) @(negedge clk);
                test_reset_n = 1'b1;
            end
            check({31'h0, in_reset_state}, 32'h1);
            host.step(1'b0, 1'b0);
            expq.push_back(id_val);
            host.scan(1'b0, 32, 32'h0, 1'b0);
            $display("test reset path %0d done", j);
        end
        conclude();
    end
endmodule : tb_top
